/* hdl/crc_unit_pkg.sv */
// Constants and types shared by the byte-serial CRC register unit.
// Functional notes
// R01: Control bits 7-5 read zero, writes ignored.
// R02: Select bit 0 gives 32-bit polynomial 0x04C11DB7.
// R03: Select bit 1 gives 16-bit polynomial 0x1021.
// R04: Writing init bit one loads whole result.
// R05: Init with value select 0 clears result.
// R06: Init with value select 1 sets all ones.
// R07: Byte pointer increments per port access, wraps.
// R08: 32-bit mode: pointer picks bytes 0 to 3.
// R09: 16-bit mode: pointer bit 0 picks byte.
// R10: Each input byte folds into current result.
// R11: Port read returns, write replaces, pointed byte.
// R12: 16-bit: XOR high byte, shift left eight.
// R13: 32-bit: XOR low byte, shift right eight.
// R14: Result holds until init, overwrite or input.
// R15: Fold completes in the cycle after write.
package crc_unit_pkg;

    // Register addresses on the special function register port.
    localparam logic [7:0] ADDR_CRC_CONTROL     = 8'h91;
    localparam logic [7:0] ADDR_CRC_RESULT_PORT = 8'h92;
    localparam logic [7:0] ADDR_CRC_BYTE_INPUT  = 8'h93;

    // Field positions inside the control register.
    localparam int CTL_SEL_BIT  = 4;
    localparam int CTL_INIT_BIT = 3;
    localparam int CTL_VAL_BIT  = 2;
    localparam int CTL_PTR_LSB  = 0;

    // Reset values of the registers.
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [7:0]  INPUT_RESET   = 8'h00;
    localparam logic [31:0] RESULT_RESET  = 32'h00000000;

    // Generator polynomials; the 32-bit engine runs reflected.
    localparam logic [31:0] POLY32      = 32'h04C11DB7;
    localparam logic [31:0] POLY32_REFL = 32'hEDB88320;
    localparam logic [15:0] POLY16      = 16'h1021;

    // The two selectable initial values of the result.
    localparam logic [31:0] INIT_ZERO = 32'h00000000;
    localparam logic [31:0] INIT_ONES = 32'hFFFFFFFF;

    // Input buffer shape.
    localparam int BYTE_W     = 8;
    localparam int FIFO_DEPTH = 32;

    // One access from the processor on the register port.
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } sfr_req_type;

endpackage

/* hdl/crc_byte_fold.sv */
// Combinational fold of one input byte into a CRC result.
`timescale 1ns/100ps
`default_nettype none

module crc_byte_fold (
    input  wire logic [31:0] result_in,
    input  wire logic [7:0]  data_byte,
    input  wire logic        sel_crc16,
    output logic      [31:0] result_out
);

    // One entry per shift step; entry 0 holds the dividend.
    logic [31:0] step32 [0:8];
    logic [15:0] step16 [0:8];

    // Reflected 32-bit: the byte enters the low end. [R13]
    assign step32[0] = result_in ^ {24'h000000, data_byte};
    // MSB-first 16-bit: the byte enters the high end. [R12]
    assign step16[0] = result_in[15:0] ^ {data_byte, 8'h00};

    // Eight shift-and-subtract steps for both algorithms.
    for (genvar i = 0; i < 8; i++) begin : g_step
        // Right shift, subtract reflected polynomial on a one out. [R02] [R13]
        assign step32[i+1] = step32[i][0] ? ((step32[i] >> 1) ^ crc_unit_pkg::POLY32_REFL)
                                          : (step32[i] >> 1);
        // Left shift, subtract polynomial on a one out. [R03] [R12]
        assign step16[i+1] = step16[i][15] ? ((step16[i] << 1) ^ crc_unit_pkg::POLY16)
                                           : (step16[i] << 1);
    end

    // The 16-bit mode leaves the upper half of the register untouched.
    assign result_out = sel_crc16 ? {result_in[31:16], step16[8]} : step32[8];

endmodule

`default_nettype wire

/* hdl/byte_fifo.sv */
// Parameterised first-word-fall-through FIFO with valid and ready.
`timescale 1ns/100ps
`default_nettype none

module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    input  wire logic             ce,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST  = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULLC = CW'(DEPTH);

    // All FIFO state; ready is kept as a flop so it leaves clean.
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wptr;
        logic [PW-1:0]               rptr;
        logic [CW-1:0]               count;
        logic                        ready;
    } fifo_state_type;

    fifo_state_type st_ff;
    fifo_state_type nxt_st;
    logic           push;
    logic           pop;

    assign in_ready  = st_ff.ready;
    assign out_valid = (st_ff.count != '0);
    assign out_data  = st_ff.mem[st_ff.rptr];
    assign push      = in_valid && st_ff.ready;
    assign pop       = out_valid && out_ready;

    // Pointer and count update; a full FIFO refuses the push.
    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wptr] = in_data;
            nxt_st.wptr = (st_ff.wptr == LAST) ? '0 : st_ff.wptr + 1'b1;
        end
        if (pop) begin
            nxt_st.rptr = (st_ff.rptr == LAST) ? '0 : st_ff.rptr + 1'b1;
        end
        nxt_st.count = st_ff.count + CW'(push) - CW'(pop);
        nxt_st.ready = (nxt_st.count != FULLC);
    end

    // State register, frozen while the clock enable is low.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '{mem: '0, wptr: '0, rptr: '0, count: '0, ready: 1'b1};
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

endmodule

`default_nettype wire

/* hdl/bytewise_crc_register_unit.sv */
// Byte-serial CRC unit reached through three special function registers.
`timescale 1ns/100ps
`default_nettype none

module bytewise_crc_register_unit #(
    parameter int FIFO_DEPTH = crc_unit_pkg::FIFO_DEPTH
) (
    input  wire logic                      clk_sys,
    input  wire logic                      nrst,
    input  wire logic                      ce,
    input  wire crc_unit_pkg::sfr_req_type sfr_req,
    output logic                     [7:0] sfr_rdata,
    output logic                           crc_input_ready
);

    // The register state of the unit, all but the input buffer, in one record.
    typedef struct packed {
        logic        sel_crc16;   // Polynomial select: 0 is 32-bit, 1 is 16-bit.
        logic        val_ones;    // Initial value select: 1 gives all ones.
        logic [1:0]  ptr;         // Result byte pointer.
        logic [31:0] result;      // Internal CRC result register.
        logic [7:0]  last_in;     // Last byte written to the input register.
        logic [7:0]  rdata;       // Registered read data for the processor.
    } crc_state_type;

    crc_state_type st_ff;         // Current state.
    crc_state_type nxt_st;        // Next state from the combinational block.

    // Decoded accesses of this cycle.
    logic        wr_ctl;          // Write to the control register.
    logic        rd_ctl;          // Read of the control register.
    logic        wr_dat;          // Write to the result port.
    logic        rd_dat;          // Read of the result port.
    logic        wr_in;           // Write to the input register.
    logic        rd_in;           // Read of the input register.
    logic        init_req;        // Control write with the init bit set.

    // Buffer and engine connections.
    logic        fifo_in_ready;   // Buffer can take another byte.
    logic        fifo_out_valid;  // Buffer holds a byte for the engine.
    logic [7:0]  fifo_out_data;   // Oldest buffered byte.
    logic        fifo_out_ready;  // Engine takes the oldest byte.
    logic [31:0] folded;          // Result with the oldest byte folded in.

    // Byte lane chosen by the pointer.
    logic [1:0]  lane;            // Lane index of the result byte.
    logic [4:0]  lane_lsb;        // Lowest bit of that lane.

    // Address decode. The port comes from logic on the same clock, so
    // it is used directly without synchronising flops.
    always_comb begin
        wr_ctl = sfr_req.wr && (sfr_req.addr == crc_unit_pkg::ADDR_CRC_CONTROL);
        rd_ctl = sfr_req.rd && (sfr_req.addr == crc_unit_pkg::ADDR_CRC_CONTROL);
        wr_dat = sfr_req.wr && (sfr_req.addr == crc_unit_pkg::ADDR_CRC_RESULT_PORT);
        rd_dat = sfr_req.rd && (sfr_req.addr == crc_unit_pkg::ADDR_CRC_RESULT_PORT);
        wr_in  = sfr_req.wr && (sfr_req.addr == crc_unit_pkg::ADDR_CRC_BYTE_INPUT);
        rd_in  = sfr_req.rd && (sfr_req.addr == crc_unit_pkg::ADDR_CRC_BYTE_INPUT);
    end

    // A control write with the init bit high starts an initialisation.
    assign init_req = wr_ctl && sfr_req.wdata[crc_unit_pkg::CTL_INIT_BIT];

    // The engine takes a buffered byte in every enabled cycle. A byte
    // written just before an init or a result-port write must fold
    // first, or it would land on the freshly loaded value; the fold is
    // applied below before the software edits overwrite it. [R15]
    assign fifo_out_ready = 1'b1;

    // Pointer to lane mapping. In 16-bit mode only pointer bit 0 counts,
    // so values 00 and 10 both address the low byte. [R08] [R09]
    always_comb begin
        if (st_ff.sel_crc16) begin
            lane = {1'b0, st_ff.ptr[0]}; // [R09]
        end else begin
            lane = st_ff.ptr; // [R08]
        end
        lane_lsb = {lane, 3'b000};
    end

    // Input buffer between the register port and the engine. The port
    // carries at most one byte per cycle and the engine drains one per
    // cycle, so the buffer never holds more than one byte. A full
    // buffer would refuse the byte, and crc_input_ready tells the
    // writer to hold off.
    byte_fifo #(
        .WIDTH (crc_unit_pkg::BYTE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_input_fifo (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .ce        (ce),
        .in_valid  (wr_in),
        .in_data   (sfr_req.wdata),
        .in_ready  (fifo_in_ready),
        .out_valid (fifo_out_valid),
        .out_data  (fifo_out_data),
        .out_ready (fifo_out_ready)
    );

    // The fold network sees the live result and the oldest byte.
    // The algorithm follows the select bit held now, so a mode change
    // takes effect for every byte folded after the control write.
    crc_byte_fold u_fold (
        .result_in  (st_ff.result),
        .data_byte  (fifo_out_data),
        .sel_crc16  (st_ff.sel_crc16),
        .result_out (folded)
    );

    // Next-state logic for the register file and the result.
    always_comb begin
        nxt_st = st_ff;

        // A byte leaving the buffer is folded into the result in the
        // same cycle it is taken, one full byte per clock. [R10] [R15]
        if (fifo_out_valid && fifo_out_ready) begin
            nxt_st.result = folded; // [R10]
        end

        // Control register write. Bits 7 to 5 have no storage, so a
        // value written there is simply dropped. [R01]
        if (wr_ctl) begin
            nxt_st.sel_crc16 = sfr_req.wdata[crc_unit_pkg::CTL_SEL_BIT];
            nxt_st.val_ones  = sfr_req.wdata[crc_unit_pkg::CTL_VAL_BIT];
            nxt_st.ptr       = sfr_req.wdata[crc_unit_pkg::CTL_PTR_LSB +: 2];
        end

        // Initialisation loads all 32 bits, also in 16-bit mode, using
        // the value select written in the same access. [R04]
        if (init_req) begin
            if (sfr_req.wdata[crc_unit_pkg::CTL_VAL_BIT]) begin
                nxt_st.result = crc_unit_pkg::INIT_ONES; // [R06]
            end else begin
                nxt_st.result = crc_unit_pkg::INIT_ZERO; // [R05]
            end
        end

        // A result port write replaces only the pointed byte. [R11]
        if (wr_dat) begin
            nxt_st.result[lane_lsb +: 8] = sfr_req.wdata; // [R11]
        end

        // Every result port access moves the pointer on by one; the
        // two-bit counter wraps from 11 to 00 by itself. A read and a
        // write in one cycle count as one access. [R07]
        if (wr_dat || rd_dat) begin
            nxt_st.ptr = st_ff.ptr + 2'b01; // [R07]
        end

        // The input register keeps the last byte offered to it.
        if (wr_in) begin
            nxt_st.last_in = sfr_req.wdata;
        end

        // Read data. A result read takes its byte from the result after
        // this cycle's fold, so a read right after an input write sees
        // the updated value. [R11] [R15]
        if (rd_ctl) begin
            // Unused upper bits and the init bit read as zero. [R01]
            nxt_st.rdata = {3'b000, st_ff.sel_crc16, 1'b0,
                            st_ff.val_ones, st_ff.ptr};
        end else if (rd_dat) begin
            nxt_st.rdata = nxt_st.result[lane_lsb +: 8]; // [R11] [R15]
        end else if (rd_in) begin
            nxt_st.rdata = st_ff.last_in;
        end else if (sfr_req.rd) begin
            // Any other address answers with zero.
            nxt_st.rdata = 8'h00;
        end
    end

    // State register. With no access and an empty buffer the result
    // simply holds; only the three events above can change it. [R14]
    // The clock enable freezes every flop, the buffer included.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '{sel_crc16: 1'b0,
                       val_ones:  1'b0,
                       ptr:       2'b00,
                       result:    crc_unit_pkg::RESULT_RESET,
                       last_in:   crc_unit_pkg::INPUT_RESET,
                       rdata:     crc_unit_pkg::CONTROL_RESET};
        end else if (ce) begin
            st_ff <= nxt_st; // [R14]
        end
    end

    // Outputs come straight from flops: read data here, buffer ready
    // from the flop inside the buffer.
    assign sfr_rdata       = st_ff.rdata;
    assign crc_input_ready = fifo_in_ready;

endmodule

`default_nettype wire

/* sim/crc_unit_asserts.sv */
// Assertion checker for the byte-serial CRC register unit.
`timescale 1ns/100ps
`default_nettype none
module crc_unit_asserts #(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic                      clk_sys,
    input wire logic                      nrst,
    input wire logic                      ce,
    input wire crc_unit_pkg::sfr_req_type sfr_req,
    input wire logic                [7:0] sfr_rdata,
    input wire logic                      crc_input_ready
);
    logic       is_ctl, is_res, is_in;     // Address decodes.
    logic       ctl_rd, res_rd, res_wr;    // Lone reads and writes taken.
    logic       res_acc, push, pop;        // Pointer step and buffer moves.
    logic [7:0] q_ff;                      // Bytes waiting in the buffer.
    logic [1:0] ptr_ff;                    // Shadow of the byte pointer.
    logic       sel_ff, val_ff;            // Shadow of the mode bits.
    assign is_ctl  = sfr_req.addr == crc_unit_pkg::ADDR_CRC_CONTROL;
    assign is_res  = sfr_req.addr == crc_unit_pkg::ADDR_CRC_RESULT_PORT;
    assign is_in   = sfr_req.addr == crc_unit_pkg::ADDR_CRC_BYTE_INPUT;
    assign ctl_rd  = ce && sfr_req.rd && !sfr_req.wr && is_ctl;
    assign res_rd  = ce && sfr_req.rd && !sfr_req.wr && is_res;
    assign res_wr  = ce && sfr_req.wr && !sfr_req.rd && is_res;
    assign res_acc = ce && (sfr_req.rd || sfr_req.wr) && is_res;
    assign push    = ce && sfr_req.wr && is_in && crc_input_ready;
    // The engine takes a queued byte in every enabled cycle.
    assign pop     = ce && (q_ff != 8'h00);
    // Shadow state lets the checks know when no byte is still queued.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            q_ff   <= 8'h00;
            ptr_ff <= 2'h0;
            sel_ff <= 1'b0;
            val_ff <= 1'b0;
        end else begin
            q_ff <= q_ff + 8'(push) - 8'(pop);
            if (ce && sfr_req.wr && is_ctl) begin
                {sel_ff, val_ff, ptr_ff} <= {sfr_req.wdata[4], sfr_req.wdata[2], sfr_req.wdata[1:0]};
            end else if (res_acc) begin
                ptr_ff <= ptr_ff + 2'h1;
            end
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    property p_ctl_read;
        ctl_rd |=> sfr_rdata == {3'h0, sel_ff, 1'b0, val_ff, ptr_ff};
    endproperty
    a_ctl_read: assert property (p_ctl_read) else $error("control readback wrong");
    property p_init;
        (ce && sfr_req.wr && is_ctl && sfr_req.wdata[3] && q_ff == 8'h00) ##1 res_rd
            |=> sfr_rdata == {8{$past(sfr_req.wdata[2], 2)}};
    endproperty
    a_init: assert property (p_init) else $error("init value wrong");
    property p_wrap;
        (res_wr && q_ff == 8'h00) ##1 res_rd [*4] |=> sfr_rdata == $past(sfr_req.wdata, 5);
    endproperty
    a_wrap: assert property (p_wrap) else $error("byte lost after pointer wrap");
    property p_mirror16;
        (res_wr && sel_ff && q_ff == 8'h00) ##1 res_rd [*2] |=> sfr_rdata == $past(sfr_req.wdata, 3);
    endproperty
    a_mirror16: assert property (p_mirror16) else $error("16-bit byte select wrong");
    property p_hold;
        !(ce && sfr_req.rd) |=> $stable(sfr_rdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved without read");
    property p_in_readback;
        (ce && sfr_req.wr && !sfr_req.rd && is_in) ##1 (ce && sfr_req.rd && !sfr_req.wr && is_in)
            |=> sfr_rdata == $past(sfr_req.wdata, 2);
    endproperty
    a_in_readback: assert property (p_in_readback) else $error("input readback wrong");
    property p_ptr_step;
        ctl_rd ##1 res_acc ##1 ctl_rd |=> sfr_rdata[1:0] == $past(sfr_rdata[1:0], 2) + 2'h1;
    endproperty
    a_ptr_step: assert property (p_ptr_step) else $error("pointer did not step");
    property p_unmapped;
        (ce && sfr_req.rd && !(is_ctl || is_res || is_in)) |=> sfr_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    c_init: cover property (p_init);
    c_wrap: cover property (p_wrap);
    c_ptr_step: cover property (p_ptr_step);
endmodule
bind bytewise_crc_register_unit crc_unit_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) u_asserts (
    .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .crc_input_ready(crc_input_ready));
`default_nettype wire

/* sim/tb.sv */
// Self-checking testbench for the byte-serial CRC register unit.
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic                      clk_sys = 1'b0;      // System clock.
    logic                      nrst = 1'b0;         // Reset, low at start.
    logic                      ce = 1'b1;           // Clock enable.
    crc_unit_pkg::sfr_req_type sfr_req = '0;        // Register request.
    logic                [7:0] sfr_rdata;           // Read data.
    logic                      crc_input_ready;     // Buffer has room.
    int                        bad_count = 0;       // Mismatches.
    int                        total_checks = 0;    // Comparisons.
    int                        cycles = 0;          // Cycle count.
    int                        seed = 32'h4C16;     // Random seed.
    logic                [7:0] exp_q[$];            // Expected reads.
    logic                      pend = 1'b0;         // Read taken last edge.
    logic               [31:0] m_res = '0;          // Model result.
    logic                [1:0] m_ptr = '0;          // Model pointer.
    logic                      m_sel = 1'b0;        // Model mode.
    logic                      m_val = 1'b0;        // Model init value.
    logic                [7:0] m_in = '0;           // Model input reg.
    always #10 clk_sys = ~clk_sys;
    bytewise_crc_register_unit #(.FIFO_DEPTH(4)) u_dut (
        .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata), .crc_input_ready(crc_input_ready));
    // Reference fold, written apart from the design's own logic.
    function automatic logic [31:0] ref_fold(input logic [31:0] r, input logic [7:0] b, input logic s);
        logic [15:0] c;
        logic [15:0] hi;
        hi = r[31:16];
        c = r[15:0] ^ {b, 8'h00};
        r = r ^ {24'h000000, b};
        for (int i = 0; i < 8; i++) begin
            c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
            r = r[0] ? ((r >> 1) ^ 32'hEDB88320) : (r >> 1);
        end
        return s ? {hi, c} : r;
    endfunction
    // Byte lane the pointer picks; 16-bit mode only uses bit 0.
    function automatic int lane();
        return m_sel ? int'(m_ptr[0]) : int'(m_ptr);
    endfunction
    task check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t: read %h, expected %h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // One request per cycle, launched just after the edge.
    task acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_req <= '{addr: a, wr: w, rd: r, wdata: d};
    endtask
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, 1'b0, a, d);
        if (a == 8'h91) begin
            {m_sel, m_val, m_ptr} = {d[4], d[2], d[1:0]};
            if (d[3]) m_res = {32{d[2]}};
        end else if (a == 8'h92) begin
            m_res[8*lane() +: 8] = d;
            m_ptr++;
        end else if (a == 8'h93) begin
            m_res = ref_fold(m_res, d, m_sel);
            m_in = d;
        end
    endtask
    // Notes the expected byte, then issues the read.
    task rd_reg(input logic [7:0] a);
        logic [7:0] e;
        e = 8'h00;
        if (a == 8'h91) e = {3'h0, m_sel, 1'b0, m_val, m_ptr};
        else if (a == 8'h93) e = m_in;
        else if (a == 8'h92) begin
            e = m_res[8*lane() +: 8];
            m_ptr++;
        end
        exp_q.push_back(e);
        acc(1'b0, 1'b1, a, 8'h00);
    endtask
    // Watcher: each taken read is compared one cycle later.
    always @(posedge clk_sys) begin
        if (pend) check(sfr_rdata, exp_q.pop_front());
        if (nrst) check({7'h00, crc_input_ready}, 8'h01);
        pend <= nrst && ce && sfr_req.rd;
    end
    // Cuts a hang short; a normal run needs about 115 cycles.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            $display("BAD %0t: timeout", $time);
            end_of_test;
        end
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        rd_reg(8'h91);
        rd_reg(8'h93);
        rd_reg(8'h90);
        wr_reg(8'h95, 8'h5A);
        repeat (4) rd_reg(8'h92);
        $display("reset values done");
        wr_reg(8'h91, 8'hFF);
        repeat (4) rd_reg(8'h92);
        rd_reg(8'h91);
        $display("control bits done");
        // Every mode with both init values, bytes back to back.
        for (int k = 0; k < 4; k++) begin
            wr_reg(8'h91, {3'h0, k[1], 1'b1, k[0], 2'h0});
            repeat (6) wr_reg(8'h93, 8'($random(seed)));
            rd_reg(8'h93);
            repeat (4) rd_reg(8'h92);
        end
        $display("fold modes done");
        wr_reg(8'h91, 8'h01);
        wr_reg(8'h92, 8'($random(seed)));
        repeat (4) rd_reg(8'h92);
        rd_reg(8'h91);
        rd_reg(8'h92);
        rd_reg(8'h91);
        // Requests with the enable low must leave everything alone.
        @(posedge clk_sys);
        ce <= 1'b0;
        sfr_req <= '{addr: 8'h93, wr: 1'b1, rd: 1'b1, wdata: 8'h3C};
        @(posedge clk_sys);
        ce <= 1'b1;
        sfr_req <= '0;
        repeat (4) rd_reg(8'h92);
        wr_reg(8'h93, 8'($random(seed)));
        repeat (4) rd_reg(8'h92);
        $display("overwrite and hold done");
        wr_reg(8'h91, 8'h12);
        wr_reg(8'h92, 8'($random(seed)));
        repeat (4) rd_reg(8'h92);
        wr_reg(8'h92, 8'($random(seed)));
        wr_reg(8'h93, 8'($random(seed)));
        rd_reg(8'h92);
        repeat (3) rd_reg(8'h92);
        $display("16-bit overwrite done");
        // A byte right before a result write or an init folds first.
        wr_reg(8'h93, 8'($random(seed)));
        wr_reg(8'h92, 8'($random(seed)));
        repeat (4) rd_reg(8'h92);
        wr_reg(8'h93, 8'($random(seed)));
        wr_reg(8'h91, 8'h0C);
        repeat (4) rd_reg(8'h92);
        $display("fold before software edit done");
        acc(1'b0, 1'b0, 8'h00, 8'h00);
        repeat (3) @(posedge clk_sys);
        end_of_test;
    end
endmodule
`default_nettype wire
